// file: rtl/tgp_port.sv
// Overview of operation
// - one range fault bit per channel, thirteen
// - status registers ignore bus writes
// - autoconfig failure sets flag bit seven
// - recalibration failure sets flag bit six
// - compare level to limits after each check
// - code 0x63 at 0x80 resets all but bus
// - bits seven to zero drive pins eleven-four
// - port registers writable in any mode
// - electrode selection overrides port enable
// - after reset all pins high impedance
// - disabled pin is off and high impedance
// - input pull modes by configuration code
// - output push-pull, open-drain or drive-high-only by code
// - output follows latch, held while charging
// - latch read gives input level for inputs
// - latch write stores even for input pins
// - set, clear, flip registers act bitwise
// - set, clear, flip read the latch
// - slave only, master drives serial clock
// - clock input only, data open-drain
// - slave address chosen by strap pin
`timescale 1ns/1ns
`default_nettype none
module tgp_port
	import tgp_pkg::*;
(
	input  wire logic         REF_CLK,
	input  wire logic         RST_N,
	input  wire logic         I2C_SCL,
	input  wire logic         SDA_I,
	output var  logic         SDA_O,
	output var  logic         SDA_OE,
	input  wire logic [1:0]   ADDR_SEL,
	input  wire tgp_check_t   CHECK,
	input  wire logic         AUTOCAL_EN,
	input  wire logic         AUTOCFG_FAIL,
	input  wire logic         RECAL_FAIL,
	input  wire logic [7:0]   ELECTRODE_SEL,
	input  wire logic         CHARGING,
	input  wire logic [7:0]   GP_IN,
	output var  tgp_pin_drv_t PIN_DRV,
	output var  logic         SOFT_RESET
);

	// ********************************************
	// bus activity seen from the reference clock
	// ********************************************
	logic [1:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic       start_q;
	logic       link_rst_q;
	logic       link_rst_n;
	logic       bus_start;
	logic       bus_stop;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			// both lines rest high, so no false edge follows reset
			scl_s_q <= 2'h3;
			sda_s_q <= 3'h7;
		end else begin
			scl_s_q <= {scl_s_q[0], I2C_SCL};
			sda_s_q <= {sda_s_q[1:0], SDA_I};
		end
	end

	assign bus_start = scl_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
	assign bus_stop  = scl_s_q[1] & ~sda_s_q[2] & sda_s_q[1];

	// link logic is held in reset between frames and pulsed at each
	// (repeated) start; start to first clock rise leaves microseconds
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_q    <= 1'b0;
			link_rst_q <= 1'b1;
		end else begin
			start_q <= bus_start;
			if (bus_start || bus_stop)
				link_rst_q <= 1'b1;
			else if (start_q)
				link_rst_q <= 1'b0;
		end
	end

	assign link_rst_n = RST_N & ~link_rst_q;

	// ********************************************
	// address strap, caught after reset release
	// ********************************************
	logic [1:0] strap_s1_q;
	logic [1:0] strap_s2_q;
	logic [2:0] strap_arm_q;
	logic [6:0] slave_addr_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			strap_s1_q   <= 2'h0;
			strap_s2_q   <= 2'h0;
			strap_arm_q  <= 3'h0;
			slave_addr_q <= TGP_SLAVE_BASE;
		end else begin
			strap_s1_q  <= ADDR_SEL;
			strap_s2_q  <= strap_s1_q;
			strap_arm_q <= {strap_arm_q[1:0], 1'b1};
			// third edge: only then has the strap left the second stage
			if (strap_arm_q == 3'h3)
				slave_addr_q <= TGP_SLAVE_BASE + {5'h00, strap_s2_q};
		end
	end

	// ********************************************
	// link side, clocked by the master's clock
	// ********************************************
	tgp_link_st_t st_q;
	logic [3:0]   cnt_q;
	logic [6:0]   sh_q;
	logic [7:0]   ptr_q;
	logic [7:0]   wr_data_q;
	logic         ack_q;
	logic         wr_tgl_q;
	logic         rd_tgl_q;
	logic [7:0]   rd_data_q;
	logic [7:0]   rx_byte;

	assign rx_byte = {sh_q, SDA_I};

	// the device only samples the clock, never drives it
	always_ff @(posedge I2C_SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt_q <= 4'h0;
			sh_q  <= 7'h00;
		end else begin
			cnt_q <= (cnt_q == TGP_ACK_SLOT) ? 4'h0 : cnt_q + 4'h1;
			if (cnt_q != TGP_ACK_SLOT)
				sh_q <= rx_byte[6:0];
		end
	end

	// frame: address byte, register byte, then data bytes
	always_ff @(posedge I2C_SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			st_q  <= TGP_LS_ADDR;
			ack_q <= 1'b0;
		end else if (cnt_q == TGP_LAST_BIT) begin
			case (st_q)
				TGP_LS_ADDR:
					ack_q <= (rx_byte[7:1] == slave_addr_q);
				TGP_LS_REG,
				TGP_LS_WDATA:
					ack_q <= 1'b1;
				default:
					ack_q <= 1'b0;
			endcase
		end else if (cnt_q == TGP_ACK_SLOT) begin
			case (st_q)
				TGP_LS_ADDR: begin
					if (!ack_q)
						st_q <= TGP_LS_IGNORE;
					else if (sh_q[0])
						st_q <= TGP_LS_RDATA;
					else
						st_q <= TGP_LS_REG;
				end
				TGP_LS_REG:
					st_q <= TGP_LS_WDATA;
				TGP_LS_WDATA:
					st_q <= TGP_LS_WDATA;
				TGP_LS_RDATA: begin
					if (SDA_I)
						st_q <= TGP_LS_IGNORE;
				end
				default:
					st_q <= TGP_LS_IGNORE;
			endcase
		end
	end

	// pointer, write byte and toggles outlive the per-frame reset:
	// a repeated start must keep the register address, and a toggle
	// forced back to zero would look like one more request
	always_ff @(posedge I2C_SCL or negedge RST_N) begin
		if (!RST_N) begin
			ptr_q     <= 8'h00;
			wr_data_q <= 8'h00;
			wr_tgl_q  <= 1'b0;
			rd_tgl_q  <= 1'b0;
		end else if (cnt_q == TGP_LAST_BIT) begin
			if (st_q == TGP_LS_REG)
				ptr_q <= rx_byte;
			if (st_q == TGP_LS_WDATA) begin
				wr_data_q <= rx_byte;
				wr_tgl_q  <= ~wr_tgl_q;
			end
		end else if (cnt_q == TGP_ACK_SLOT) begin
			if (st_q == TGP_LS_WDATA)
				ptr_q <= ptr_q + 8'h01;
			if ((st_q == TGP_LS_ADDR) && ack_q && sh_q[0])
				rd_tgl_q <= ~rd_tgl_q;
			if ((st_q == TGP_LS_RDATA) && !SDA_I) begin
				ptr_q    <= ptr_q + 8'h01;
				rd_tgl_q <= ~rd_tgl_q;
			end
		end
	end

	// data changes only while the clock is low; rd_data_q is held
	// by the reference side until the next request toggle
	always_ff @(negedge I2C_SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			SDA_OE <= 1'b0;
			SDA_O  <= 1'b0;
		end else begin
			SDA_O <= 1'b0;
			if (cnt_q == TGP_ACK_SLOT)
				SDA_OE <= ack_q;
			else if (st_q == TGP_LS_RDATA)
				SDA_OE <= ~rd_data_q[3'h7 - cnt_q[2:0]];
			else
				SDA_OE <= 1'b0;
		end
	end

	// ********************************************
	// request crossing into the reference clock
	// ********************************************
	logic [2:0] wr_sync_q;
	logic [2:0] rd_sync_q;
	logic       wr_ev;
	logic       rd_ev;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_sync_q <= 3'h0;
			rd_sync_q <= 3'h0;
		end else begin
			wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
			rd_sync_q <= {rd_sync_q[1:0], rd_tgl_q};
		end
	end

	assign wr_ev = wr_sync_q[2] ^ wr_sync_q[1];
	assign rd_ev = rd_sync_q[2] ^ rd_sync_q[1];

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_ev && (ptr_q == ofs);
	endfunction

	// ********************************************
	// soft reset, never touches the bus logic
	// ********************************************
	logic soft_rst_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= wr_hit(TGP_OFS_SOFT_RST) &&
				(wr_data_q == TGP_SOFT_RST_CODE);
	end

	assign SOFT_RESET = soft_rst_q;

	// ********************************************
	// range status and fail flags
	// ********************************************
	logic [12:0] range_q;
	logic        autoconfig_fail_flag_q;
	logic        recal_fail_flag_q;
	logic        out_of_range;

	assign out_of_range =
		(CHECK.level > {CHECK.upper_level_limit, 2'h0}) ||
		(CHECK.level < {CHECK.lower_level_limit, 2'h0});

	// no write path exists to these bits
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			range_q <= TGP_RANGE_RST;
		else if (soft_rst_q)
			range_q <= TGP_RANGE_RST;
		else if (AUTOCAL_EN && CHECK.valid &&
				(CHECK.chan < 4'(TGP_NUM_CHAN)))
			range_q[CHECK.chan] <= out_of_range;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			autoconfig_fail_flag_q <= 1'b0;
			recal_fail_flag_q <= 1'b0;
		end else if (soft_rst_q) begin
			autoconfig_fail_flag_q <= 1'b0;
			recal_fail_flag_q <= 1'b0;
		end else begin
			if (AUTOCFG_FAIL)
				autoconfig_fail_flag_q <= 1'b1;
			if (RECAL_FAIL)
				recal_fail_flag_q <= 1'b1;
		end
	end

	// ********************************************
	// port registers, writable in stop and run mode
	// ********************************************
	logic [7:0] cfg_a_q;
	logic [7:0] cfg_b_q;
	logic [7:0] latch_q;
	logic [7:0] way_q;
	logic [7:0] en_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_a_q <= TGP_PORT_RST;
			cfg_b_q <= TGP_PORT_RST;
			way_q   <= TGP_PORT_RST;
			en_q    <= TGP_PORT_RST;
		end else if (soft_rst_q) begin
			cfg_a_q <= TGP_PORT_RST;
			cfg_b_q <= TGP_PORT_RST;
			way_q   <= TGP_PORT_RST;
			en_q    <= TGP_PORT_RST;
		end else begin
			if (wr_hit(TGP_OFS_CFG_A))
				cfg_a_q <= wr_data_q;
			if (wr_hit(TGP_OFS_CFG_B))
				cfg_b_q <= wr_data_q;
			if (wr_hit(TGP_OFS_WAY))
				way_q <= wr_data_q;
			if (wr_hit(TGP_OFS_EN))
				en_q <= wr_data_q;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			latch_q <= TGP_PORT_RST;
		else if (soft_rst_q)
			latch_q <= TGP_PORT_RST;
		else if (wr_hit(TGP_OFS_LATCH))
			latch_q <= wr_data_q;
		else if (wr_hit(TGP_OFS_SET))
			latch_q <= latch_q | wr_data_q;
		else if (wr_hit(TGP_OFS_CLR))
			latch_q <= latch_q & ~wr_data_q;
		else if (wr_hit(TGP_OFS_FLIP))
			latch_q <= latch_q ^ wr_data_q;
	end

	// ********************************************
	// pins: input capture and output drive
	// ********************************************
	logic [7:0] in_s1_q;
	logic [7:0] in_s2_q;
	logic [7:0] lvl_q;
	wire  logic [7:0] active;
	wire  logic [7:0] out_d;
	wire  logic [7:0] oe_d;
	wire  logic [7:0] pu_d;
	wire  logic [7:0] pd_d;
	tgp_pin_drv_t     drv_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			in_s1_q <= 8'h00;
			in_s2_q <= 8'h00;
			lvl_q   <= TGP_PORT_RST;
		end else begin
			in_s1_q <= GP_IN;
			in_s2_q <= in_s1_q;
			// level moves only once the conversion is over
			if (!CHARGING)
				lvl_q <= latch_q;
		end
	end

	assign active = en_q & ~ELECTRODE_SEL;

	// bit i of every port register belongs to sense pin i+4
	for (genvar i = 0; i < TGP_NUM_PIN; i++) begin : g_pin
		logic [1:0] code;
		assign code = ({cfg_a_q[i], cfg_b_q[i]} == TGP_CFG_UNDEF) ?
			TGP_CFG_PLAIN : {cfg_a_q[i], cfg_b_q[i]};
		assign out_d[i] = (code == TGP_CFG_PLAIN) ? lvl_q[i] :
			(code == TGP_CFG_HIGH);
		assign oe_d[i] = active[i] & way_q[i] &
			((code == TGP_CFG_PLAIN) ||
			 ((code == TGP_CFG_HIGH) && lvl_q[i]) ||
			 ((code == TGP_CFG_LOW) && !lvl_q[i]));
		assign pu_d[i] = active[i] & ~way_q[i] &
			(code == TGP_CFG_HIGH);
		assign pd_d[i] = active[i] & ~way_q[i] &
			(code == TGP_CFG_LOW);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			drv_q <= '0;
		else
			drv_q <= '{out: out_d, oe: oe_d, pull_up: pu_d,
				pull_dn: pd_d};
	end

	assign PIN_DRV = drv_q;

	// ********************************************
	// read side of the register file
	// ********************************************
	function automatic logic [7:0] read_value(input logic [7:0] ofs);
		logic [7:0] port_view;
		port_view = (way_q & latch_q) | (~way_q & in_s2_q);
		case (ofs)
			TGP_OFS_RANGE_LO: read_value = range_q[7:0];
			TGP_OFS_RANGE_HI: read_value = {autoconfig_fail_flag_q, recal_fail_flag_q, 1'b0,
				range_q[12:8]};
			TGP_OFS_CFG_A:    read_value = cfg_a_q;
			TGP_OFS_CFG_B:    read_value = cfg_b_q;
			TGP_OFS_WAY:      read_value = way_q;
			TGP_OFS_EN:       read_value = en_q;
			TGP_OFS_LATCH,
			TGP_OFS_SET,
			TGP_OFS_CLR,
			TGP_OFS_FLIP:     read_value = port_view;
			default:          read_value = TGP_UNMAPPED;
		endcase
	endfunction

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			rd_data_q <= 8'h00;
		else if (rd_ev)
			rd_data_q <= read_value(ptr_q);
	end

	// ********************************************
	// checks
	// ********************************************
	sequence soft_wr_s;
		wr_hit(TGP_OFS_SOFT_RST) && (wr_data_q == TGP_SOFT_RST_CODE);
	endsequence

	sequence port_clear_s;
		(en_q == 8'h00) && (latch_q == 8'h00) && (way_q == 8'h00) &&
		(range_q == 13'h0000) && !autoconfig_fail_flag_q && !recal_fail_flag_q;
	endsequence

	soft_clear_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		soft_wr_s |-> ##2 port_clear_s)
		else $error("soft reset left state behind");

	status_ro_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		(wr_hit(TGP_OFS_RANGE_LO) || wr_hit(TGP_OFS_RANGE_HI)) &&
		!CHECK.valid && !soft_rst_q |=> $stable(range_q))
		else $error("status changed by a bus write");

	autoconfig_fail_flag_set_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		AUTOCFG_FAIL && !soft_rst_q |=> autoconfig_fail_flag_q)
		else $error("autoconfig fail flag not set");

	recal_fail_flag_set_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		RECAL_FAIL && !soft_rst_q |=> recal_fail_flag_q)
		else $error("recal fail flag not set");

	range_check_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		AUTOCAL_EN && CHECK.valid && (CHECK.chan < 4'hd) && !soft_rst_q
		|=> range_q[$past(CHECK.chan)] == $past(out_of_range))
		else $error("range bit does not follow the check");

	bit_set_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		wr_hit(TGP_OFS_SET) && !soft_rst_q
		|=> latch_q == ($past(latch_q) | $past(wr_data_q)))
		else $error("set register did not set latch bits");

	elec_wins_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		(ELECTRODE_SEL != 8'h00) ##1 $stable(ELECTRODE_SEL)
		|-> (PIN_DRV.oe & ELECTRODE_SEL) == 8'h00)
		else $error("port drives a pin owned by an electrode");

	dis_hiz_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		$stable(en_q) && $past(en_q) != 8'hff
		|-> ((PIN_DRV.oe | PIN_DRV.pull_up | PIN_DRV.pull_dn) & ~en_q)
			== 8'h00)
		else $error("disabled pin not high impedance");

	charge_hold_a: assert property (
		@(posedge REF_CLK) disable iff (!RST_N)
		CHARGING [*2] |-> $stable(lvl_q))
		else $error("output level moved while charging");

	sda_drain_a: assert property (
		@(negedge I2C_SCL) disable iff (!link_rst_n)
		SDA_OE |-> (SDA_O == 1'b0))
		else $error("data line driven high");

endmodule
`default_nettype wire

// file: pkg/tgp_pkg.sv
`default_nettype none
package tgp_pkg;

	// ********************************************
	// register map
	// ********************************************
	localparam logic [7:0] TGP_OFS_RANGE_LO  = 8'h02;
	localparam logic [7:0] TGP_OFS_RANGE_HI  = 8'h03;
	localparam logic [7:0] TGP_OFS_CFG_A     = 8'h73;
	localparam logic [7:0] TGP_OFS_CFG_B     = 8'h74;
	localparam logic [7:0] TGP_OFS_LATCH     = 8'h75;
	localparam logic [7:0] TGP_OFS_WAY       = 8'h76;
	localparam logic [7:0] TGP_OFS_EN        = 8'h77;
	localparam logic [7:0] TGP_OFS_SET       = 8'h78;
	localparam logic [7:0] TGP_OFS_CLR       = 8'h79;
	localparam logic [7:0] TGP_OFS_FLIP      = 8'h7a;
	localparam logic [7:0] TGP_OFS_SOFT_RST  = 8'h80;
	localparam logic [7:0] TGP_SOFT_RST_CODE = 8'h63;

	// ********************************************
	// field layout and reset values
	// ********************************************
	localparam int          TGP_NUM_CHAN    = 13;
	localparam int          TGP_NUM_PIN     = 8;
	localparam int          TGP_AUTOCONFIG_FAIL_FLAG_BIT    = 7;
	localparam int          TGP_RECAL_FAIL_FLAG_BIT    = 6;
	localparam logic [12:0] TGP_RANGE_RST   = 13'h0000;
	localparam logic [7:0]  TGP_PORT_RST    = 8'h00;
	localparam logic [7:0]  TGP_UNMAPPED    = 8'h00;
	localparam logic [6:0]  TGP_SLAVE_BASE  = 7'h5a;
	localparam logic [1:0]  TGP_CFG_PLAIN   = 2'h0;
	localparam logic [1:0]  TGP_CFG_UNDEF   = 2'h1;
	localparam logic [1:0]  TGP_CFG_LOW     = 2'h2;
	localparam logic [1:0]  TGP_CFG_HIGH    = 2'h3;
	localparam logic [3:0]  TGP_ACK_SLOT    = 4'h8;
	localparam logic [3:0]  TGP_LAST_BIT    = 4'h7;

	// ********************************************
	// types
	// ********************************************
	typedef enum logic [2:0] {
		TGP_LS_ADDR,
		TGP_LS_REG,
		TGP_LS_WDATA,
		TGP_LS_RDATA,
		TGP_LS_IGNORE
	} tgp_link_st_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] pull_dn;
	} tgp_pin_drv_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  chan;
		logic [9:0]  level;
		logic [7:0]  upper_level_limit;
		logic [7:0]  lower_level_limit;
	} tgp_check_t;

endpackage
`default_nettype wire

// file: verif/tgp_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module tgp_i2c_master (
	output var  logic scl,
	output var  logic sda_oe,
	input  wire logic sda
);
	// ********************************
	// bit timing on a 6 ns tick
	// ********************************
	// long phases leave room for the slave's sync into its system clock
	localparam int HALF = 60;
	logic tick;

	initial begin
		tick = 1'b0;
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	always #3 tick = ~tick;

	task automatic wt(input int n);
		repeat (n) @(posedge tick);
	endtask

	// scl stands high between frames
	task automatic start;
		sda_oe = 1'b0;
		wt(HALF);
		scl = 1'b1;
		wt(HALF);
		sda_oe = 1'b1;
		wt(HALF);
		scl = 1'b0;
		wt(HALF / 2);
	endtask

	task automatic stop;
		sda_oe = 1'b1;
		wt(HALF);
		scl = 1'b1;
		wt(HALF);
		sda_oe = 1'b0;
		wt(2 * HALF);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_oe = ~b;
		wt(HALF);
		scl = 1'b1;
		wt(HALF / 2);
		r = sda;
		wt(HALF / 2);
		scl = 1'b0;
		wt(HALF / 2);
	endtask

	// ninth slot always released: ack of slave, or nak after a read
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
			output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] r,
			input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic k;
		start;
		byte_io({a, 1'b0}, q, ack);
		byte_io(r, q, k);
		byte_io(d, q, k);
		stop;
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] r,
			output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start;
		byte_io({a, 1'b0}, q, k);
		byte_io(r, q, k);
		start;
		byte_io({a, 1'b1}, q, k);
		byte_io(8'hff, d, k);
		stop;
	endtask
endmodule
`default_nettype wire

// file: verif/test_touch_gpio_status_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_touch_gpio_status_port
	import tgp_pkg::*;
;
	logic         ref_clk, rst_n, scl, m_oe, sda, sda_o, sda_oe, srst;
	logic         acal, acf, rcf, chg, ak;
	logic [1:0]   addr_sel;
	logic [6:0]   adr;
	logic [7:0]   esel, gin, v, p_en, p_way, p_a, p_b, p_lat;
	logic [12:0]  st;
	logic [1:0]   fl;
	tgp_check_t   chk_in;
	tgp_pin_drv_t drv;
	int           num_errors = 0;
	int           n_tests = 0;
	int           sr_seen = 0;
	logic [7:0]   offs [8] = '{8'h02, 8'h03, 8'h73, 8'h74, 8'h75, 8'h76,
		8'h77, 8'h50};

	assign sda = ~(m_oe | (sda_oe & ~sda_o));
	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (srst === 1'b1) sr_seen <= sr_seen + 1;

	tgp_i2c_master m (.scl(scl), .sda_oe(m_oe), .sda(sda));

	tgp_port dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .I2C_SCL(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
		.CHECK(chk_in), .AUTOCAL_EN(acal), .AUTOCFG_FAIL(acf),
		.RECAL_FAIL(rcf), .ELECTRODE_SEL(esel), .CHARGING(chg),
		.GP_IN(gin), .PIN_DRV(drv), .SOFT_RESET(srst)
	);

	// ********************************
	// checking helpers
	// ********************************
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic w(input logic [7:0] r, input logic [7:0] d);
		m.wr(adr, r, d, ak);
		check("ack", 32'h1, 32'(ak));
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] r, input logic [7:0] e,
			input string nm);
		logic [7:0] d;
		m.rd(adr, r, d);
		check(nm, 32'(e), 32'(d));
		@(negedge ref_clk);
	endtask

	task automatic rst;
		rst_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		{st, fl, p_en, p_way, p_a, p_b, p_lat} = '0;
		repeat (6) @(negedge ref_clk);
	endtask

	function automatic logic [7:0] lview;
		return (p_lat & p_way) | (gin & ~p_way);
	endfunction

	// disabled or electrode pins: every drive and pull off
	function automatic tgp_pin_drv_t exp_drv(input logic [7:0] lat);
		tgp_pin_drv_t d;
		logic [7:0] on;
		on = p_en & ~esel;
		d.pull_dn = on & ~p_way & p_a & ~p_b;
		d.pull_up = on & ~p_way & p_a & p_b;
		d.oe = on & p_way & (~p_a | ~(p_b ^ lat));
		d.out = ((~p_a & lat) | (p_a & p_b)) & d.oe;
		return d;
	endfunction

	task automatic chk_drv(input logic [7:0] lat);
		tgp_pin_drv_t d;
		d = exp_drv(lat);
		check("oe", 32'(d.oe), 32'(drv.oe));
		check("out", 32'(d.out), 32'(drv.out & drv.oe));
		check("pull", 32'({d.pull_up, d.pull_dn}),
			32'({drv.pull_up, drv.pull_dn}));
	endtask

	task automatic setport;
		w(TGP_OFS_CFG_A, p_a);
		w(TGP_OFS_CFG_B, p_b);
		w(TGP_OFS_WAY, p_way);
		w(TGP_OFS_EN, p_en);
		w(TGP_OFS_LATCH, p_lat);
	endtask

	// levels placed around the window so both outcomes occur
	task automatic pulse;
		logic [9:0] lo, up;
		@(negedge ref_clk);
		chk_in.chan = 4'($urandom % 13);
		chk_in.lower_level_limit = 8'($urandom);
		chk_in.upper_level_limit = chk_in.lower_level_limit + 8'($urandom % 64);
		lo = {chk_in.lower_level_limit, 2'b00};
		up = {chk_in.upper_level_limit, 2'b00};
		chk_in.level = lo + 10'($urandom % 300) - 10'h028;
		chk_in.valid = 1'b1;
		acal = ($urandom % 4) != 0;
		if (acal)
			st[chk_in.chan] = (chk_in.level < lo) || (chk_in.level > up);
		@(negedge ref_clk);
		chk_in.valid = 1'b0;
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		{addr_sel, acal, acf, rcf, esel, chg, gin} = '0;
		chk_in = '0;
		void'($urandom(62));
		for (int k = 0; k < 4; k++) begin
			addr_sel = 2'(k);
			rst;
			check("drv", 32'h0, drv);
			check("sda", 32'h0, 32'({sda_oe, srst}));
			m.wr(TGP_SLAVE_BASE + 7'((k + 1) % 4), TGP_OFS_EN, 8'hff, ak);
			check("nak", 32'h0, 32'(ak));
			adr = TGP_SLAVE_BASE + 7'(k);
			w(TGP_OFS_EN, 8'h00);
		end
		foreach (offs[i]) rd(offs[i], 8'h00, "rst");
		for (int i = 0; i < 4; i++) begin
			repeat (24) pulse;
			@(negedge ref_clk);
			acf = (i == 1);
			rcf = (i == 2);
			fl = fl | {acf, rcf};
			@(negedge ref_clk);
			acf = 1'b0;
			rcf = 1'b0;
			rd(TGP_OFS_RANGE_LO, st[7:0], "lo");
			rd(TGP_OFS_RANGE_HI, {fl, 1'b0, st[12:8]}, "hi");
			w(TGP_OFS_RANGE_LO, ~st[7:0]);
			w(TGP_OFS_RANGE_HI, 8'hff);
			rd(TGP_OFS_RANGE_LO, st[7:0], "lo_w");
			rd(TGP_OFS_RANGE_HI, {fl, 1'b0, st[12:8]}, "hi_w");
		end
		for (int i = 0; i < 6; i++) begin
			{p_en, p_way, p_a, p_b} = $urandom;
			p_lat = 8'($urandom);
			gin = 8'($urandom);
			esel = (i < 3) ? 8'h00 : 8'($urandom);
			setport;
			chk_drv(p_lat);
			rd(TGP_OFS_LATCH, lview(), "latch");
		end
		p_way = 8'h00;
		w(TGP_OFS_WAY, p_way);
		p_lat = 8'($urandom);
		w(TGP_OFS_LATCH, p_lat);
		rd(TGP_OFS_LATCH, gin, "in");
		p_way = 8'hff;
		w(TGP_OFS_WAY, p_way);
		rd(TGP_OFS_LATCH, p_lat, "kept");
		for (int k = 0; k < 9; k++) begin
			v = 8'($urandom);
			w(TGP_OFS_SET + 8'(k % 3), v);
			case (k % 3)
				0: p_lat = p_lat | v;
				1: p_lat = p_lat & ~v;
				default: p_lat = p_lat ^ v;
			endcase
			rd(TGP_OFS_SET + 8'((k + 1) % 3), p_lat, "bits");
		end
		{p_en, esel, p_a, p_b} = {8'hff, 8'h00, 8'h00, 8'h00};
		setport;
		chg = 1'b1;
		v = p_lat;
		p_lat = ~p_lat;
		w(TGP_OFS_LATCH, p_lat);
		chk_drv(v);
		chg = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk_drv(p_lat);
		w(TGP_OFS_SOFT_RST, 8'h62);
		check("nosr", 32'h0, 32'(sr_seen));
		rd(TGP_OFS_EN, 8'hff, "en");
		w(TGP_OFS_SOFT_RST, TGP_SOFT_RST_CODE);
		check("sr", 32'h1, 32'(sr_seen));
		check("drv0", 32'h0, drv);
		rd(TGP_OFS_EN, 8'h00, "en0");
		rd(TGP_OFS_RANGE_HI, 8'h00, "hi0");
		final_report;
	end

	initial begin
		#5000000;
		num_errors++;
		final_report;
	end
endmodule
`default_nettype wire
